//--- rtl/jfp_port.sv
// Scan-side flash register port: tap, registers, flash sequencer
`timescale 1ns/1ps
// Overview of operation
// R1 - Data byte sits in data register bits 9:2
// R2 - Fail flag reflects last operation outcome
// R3 - Busy flag high while operation runs
// R4 - Accesses during busy start nothing
// R5 - One-shot bit picks 50 ns strobe
// R6 - Read-always keeps sense enable on
// R7 - Scale bits 5:4 read zero
// R8 - Host sets prescale before write/erase
// R9 - Host picks prescale from clock rate
// R10 - All-ones prescale refuses all flash operations
// R11 - No boundary scan; bypass and identity supported
// R12 - Bypass gives one-bit register
// R13 - Identity register has version/part/maker/one
// R14 - Watchdog held off while halted
// R15 - Peripherals keep running during debug
// R16 - Program mode writes byte, increments address
// R17 - Erase mode needs key byte 0xa5
// R18 - Opcode: 0x poll, 10 read, 11 write
// R19 - Shift-out: busy first, right-justified data (code puts data at bits 18:5, with bits 4:1 zero)
// R20 - Scan writes cannot change fail/busy
module jfp_port
    import jfp_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // Scan pins
    input  wire logic              tck_i,
    input  wire logic              tms_i,
    input  wire logic              tdi_i,
    output logic                   tdo_o,
    output logic                   tdo_oe_o,
    // Flash array
    output jfp_flash_req_type      flash_o,
    input  wire jfp_flash_rsp_type flash_i,
    // Debug
    input  wire logic              cpu_halted_i,
    output logic                   watchdog_hold_o,
    output logic                   periph_freeze_o
);
    // ************************************************************
    // Pin sampling and tck edges
    // ************************************************************
    logic [2:0]  pins_s;          // tck, tms, tdi synchronised
    logic        tck_d_r;         // Previous tck level
    logic        rise, fall;      // Tck edges
    jfp_sync u_sync (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
                     .async_i({tck_i, tms_i, tdi_i}), .sync_o(pins_s));
    assign rise = pins_s[2] & ~tck_d_r;
    assign fall = ~pins_s[2] & tck_d_r;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            tck_d_r <= 1'b0;
        else if (ce_i)
            tck_d_r <= pins_s[2];
    end

    // ************************************************************
    // Tap controller
    // ************************************************************
    jfp_tap_type tap_r, tap_nxt;  // Tap state
    always_comb
    begin
        case (tap_r)
            TS_RESET:  tap_nxt = pins_s[1] ? TS_RESET  : TS_IDLE;
            TS_IDLE:   tap_nxt = pins_s[1] ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: tap_nxt = pins_s[1] ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: tap_nxt = pins_s[1] ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR:  tap_nxt = pins_s[1] ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: tap_nxt = pins_s[1] ? TS_UP_DR  : TS_PA_DR;
            TS_PA_DR:  tap_nxt = pins_s[1] ? TS_EX2_DR : TS_PA_DR;
            TS_EX2_DR: tap_nxt = pins_s[1] ? TS_UP_DR  : TS_SH_DR;
            TS_UP_DR:  tap_nxt = pins_s[1] ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: tap_nxt = pins_s[1] ? TS_RESET  : TS_CAP_IR;
            TS_CAP_IR: tap_nxt = pins_s[1] ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR:  tap_nxt = pins_s[1] ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: tap_nxt = pins_s[1] ? TS_UP_IR  : TS_PA_IR;
            TS_PA_IR:  tap_nxt = pins_s[1] ? TS_EX2_IR : TS_PA_IR;
            TS_EX2_IR: tap_nxt = pins_s[1] ? TS_UP_IR  : TS_SH_IR;
            TS_UP_IR:  tap_nxt = pins_s[1] ? TS_SEL_DR : TS_IDLE;
            default:   tap_nxt = TS_RESET;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            tap_r <= TS_RESET;
        else if (ce_i && rise)
            tap_r <= tap_nxt;
    end

    // ************************************************************
    // Instruction and data shift registers
    // ************************************************************
    logic [15:0]  ir_sh_r, ir_r;  // Instruction shift and hold
    logic [31:0]  dr_sh_r;        // Shared data shift path
    logic [31:0]  ident;          // Identity word
    logic         is_ind;         // Indirect register selected
    logic [15:0]  addr_r;         // Flash address
    logic [9:0]   data_r;         // Flash data
    logic [7:0]   scale_r;        // Flash scale
    logic [7:0]   ctrl_r;         // Flash control
    logic         busy_r, fail_r; // Sequencer flags
    logic [19:0]  cap_word;       // Indirect capture value
    logic [17:0]  rd_val;         // Selected register value
    logic [17:0]  wdata;          // Write data left-justified
    logic [1:0]   opc;            // Indirect opcode

    assign ident  = {ID_VERSION, ID_PART[15:0], ID_MAKER, 1'b1}; // [R13] [R11]
    assign is_ind = (ir_r == IR_FCTRL) || (ir_r == IR_FDATA) ||
                    (ir_r == IR_FADDR) || (ir_r == IR_FSCALE);

    // Read value of the selected register, right-justified
    always_comb
    begin
        case (ir_r)
            IR_FCTRL:  rd_val = {10'h000, ctrl_r};
            IR_FDATA:  rd_val = {8'h00, data_r[DAT_MSB:DAT_LSB], fail_r, busy_r}; // [R1] [R2]
            IR_FADDR:  rd_val = {2'b00, addr_r};
            IR_FSCALE: rd_val = {10'h000, scale_r & SCL_WMASK}; // [R7]
            default:   rd_val = 18'h00000;
        endcase
    end
    // Busy first, then 14 data bits at 18:5 (flash data needs only 10)
    assign cap_word = {1'b0, rd_val[13:0], 4'h0, busy_r}; // [R19]

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ir_sh_r <= 16'h0000;
            ir_r    <= IR_IDENT;
            dr_sh_r <= 32'h0;
        end
        else if (ce_i && rise)
        begin
            case (tap_r)
                TS_RESET:  ir_r    <= IR_IDENT;
                TS_CAP_IR: ir_sh_r <= 16'h0001;
                TS_SH_IR:  ir_sh_r <= {pins_s[0], ir_sh_r[15:1]};
                TS_UP_IR:  ir_r    <= ir_sh_r;
                TS_CAP_DR:
                    if (ir_r == IR_IDENT)
                        dr_sh_r <= ident;
                    else if (is_ind)
                        dr_sh_r <= {12'h000, cap_word};
                    else
                        dr_sh_r <= 32'h0;                   // [R12]
                TS_SH_DR:
                    if (ir_r == IR_IDENT)
                        dr_sh_r <= {pins_s[0], dr_sh_r[31:1]};
                    else if (is_ind)
                        dr_sh_r <= {12'h000, pins_s[0], dr_sh_r[19:1]};
                    else
                        dr_sh_r <= {31'h0, pins_s[0]};      // [R12]
                default: ;
            endcase
        end
    end

    // Data out changes on the falling edge of tck
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end
        else if (ce_i && fall)
        begin
            tdo_oe_o <= (tap_r == TS_SH_DR) || (tap_r == TS_SH_IR);
            tdo_o    <= (tap_r == TS_SH_IR) ? ir_sh_r[0] : dr_sh_r[0];
        end
    end

    // ************************************************************
    // Indirect update decode
    // ************************************************************
    logic upd;                    // Update-DR on indirect register
    logic do_wr, do_rd;           // Accepted write / read
    logic flash_ok;               // Prescale permits flash access
    logic start_prog, start_erase, start_read;
    logic data_unread_r;          // Single-read mode: result not consumed
    logic rd_op_r;                // Running operation is a flash read

    assign upd      = ce_i && rise && (tap_r == TS_UP_DR) && is_ind;
    assign opc      = dr_sh_r[19:18];
    assign wdata    = dr_sh_r[17:0];
    assign do_wr    = upd && (opc == 2'b11) && !busy_r;   // [R18] [R4]
    assign do_rd    = upd && (opc == 2'b10) && !busy_r;   // [R18] [R4]
    assign flash_ok = scale_r[3:0] != PRESC_OFF;          // [R10]
    assign start_prog  = do_wr && (ir_r == IR_FDATA) && (ctrl_r[7:4] == WM_PROG);  // [R16]
    assign start_erase = do_wr && (ir_r == IR_FDATA) && (ctrl_r[7:4] == WM_ERASE)
                         && (wdata[17:10] == ERASE_KEY);  // [R17]
    assign start_read  = do_rd && (ir_r == IR_FDATA) &&
                         ((ctrl_r[3:0] == RM_BLOCK) ||
                          ((ctrl_r[3:0] == RM_SINGLE) && !data_unread_r));

    // Register writes; flags are never written by scan
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_r  <= CTRL_RST;
            scale_r <= SCALE_RST;
            data_r  <= DATA_RST;
        end
        else if (ce_i)
        begin
            if (do_wr && ir_r == IR_FCTRL)
                ctrl_r <= wdata[17:10];
            if (do_wr && ir_r == IR_FSCALE)
                scale_r <= wdata[17:10] & SCL_WMASK;      // [R7]
            if (do_wr && ir_r == IR_FDATA)
                data_r <= {wdata[17:10], 2'b00};          // [R1] [R20]
            // Strobe may end long before done, so key on the operation
            else if (flash_i.done && rd_op_r)
                data_r <= {flash_i.rdata, 2'b00};         // [R1]
        end
    end

    // ************************************************************
    // Flash sequencer
    // ************************************************************
    jfp_fsm_type fs_r;            // Sequencer state
    logic [CYC_W-1:0] str_cnt_r;  // Read strobe width counter

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fs_r          <= FS_IDLE;
            busy_r        <= 1'b0;
            fail_r        <= 1'b0;
            addr_r        <= ADDR_RST;
            flash_o       <= '0;
            str_cnt_r     <= '0;
            data_unread_r <= 1'b0;
            rd_op_r       <= 1'b0;
        end
        else if (ce_i)
        begin
            flash_o.sense <= scale_r[SCL_RAE] | flash_o.rd; // [R6]
            flash_o.presc <= scale_r[3:0];
            if (do_rd && ir_r == IR_FDATA)
                data_unread_r <= 1'b0;
            if (do_wr && ir_r == IR_FADDR)
                addr_r <= wdata[17:2];
            case (fs_r)
                FS_IDLE:
                    if (start_prog || start_erase || start_read)
                    begin
                        busy_r <= 1'b1;                   // [R3]
                        if (!flash_ok)
                        begin
                            fail_r <= 1'b1;               // [R10]
                            fs_r   <= FS_DONE;
                        end
                        else
                        begin
                            flash_o.rd    <= start_read;
                            flash_o.sense <= scale_r[SCL_RAE] | start_read; // [R6]
                            rd_op_r       <= start_read;
                            flash_o.wr    <= start_prog;
                            flash_o.erase <= start_erase;
                            flash_o.addr  <= addr_r;
                            flash_o.wdata <= wdata[17:10];
                            str_cnt_r     <= scale_r[SCL_OSE] ? CYC_W'(OSE_CYC)
                                                              : CYC_W'(1); // [R5]
                            fs_r          <= FS_RUN;
                        end
                    end
                FS_RUN:
                begin
                    if (str_cnt_r != '0)
                        str_cnt_r <= str_cnt_r - CYC_W'(1);
                    if (flash_i.done)
                    begin
                        fail_r <= flash_i.fail;           // [R2]
                        if (flash_o.wr)
                            addr_r <= addr_r + 16'h0001;  // [R16]
                        if (rd_op_r)
                            data_unread_r <= 1'b1;
                        rd_op_r       <= 1'b0;
                        flash_o.sense <= scale_r[SCL_RAE];
                        flash_o.rd    <= 1'b0;
                        flash_o.wr    <= 1'b0;
                        flash_o.erase <= 1'b0;
                        fs_r          <= FS_DONE;
                    end
                    else if (str_cnt_r == CYC_W'(1))
                    begin
                        flash_o.rd    <= 1'b0;            // [R5]
                        flash_o.sense <= scale_r[SCL_RAE]; // [R6]
                    end
                end
                FS_DONE:
                begin
                    busy_r <= 1'b0;                       // [R3]
                    fs_r   <= FS_IDLE;
                end
                default: fs_r <= FS_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Debug side effects
    // ************************************************************
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            watchdog_hold_o <= 1'b0;
            periph_freeze_o <= 1'b0;
        end
        else if (ce_i)
        begin
            watchdog_hold_o <= cpu_halted_i;              // [R14]
            periph_freeze_o <= 1'b0;                      // [R15]
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_busy_blocks: assert property (@(posedge clock_i) disable iff (rst_i) // [R4]
        busy_r |=> !($rose(flash_o.rd) || $rose(flash_o.wr) || $rose(flash_o.erase)))
        else $error("operation started while busy");
    a_presc_refuse: assert property (@(posedge clock_i) disable iff (rst_i) // [R10]
        (fs_r == FS_IDLE && flash_o.presc == PRESC_OFF && scale_r[3:0] == PRESC_OFF)
        |=> !(flash_o.wr || flash_o.erase))
        else $error("flash access with prescale all ones");
    a_scale_zero: assert property (@(posedge clock_i) disable iff (rst_i) // [R7]
        scale_r[5:4] == 2'b00)
        else $error("scale bits 5:4 not zero");
    a_wdog_hold: assert property (@(posedge clock_i) disable iff (rst_i) // [R14]
        ce_i && cpu_halted_i |=> watchdog_hold_o)
        else $error("watchdog not held while halted");
    a_busy_set: assert property (@(posedge clock_i) disable iff (rst_i) // [R3]
        ce_i && (start_prog || start_read) |=> busy_r)
        else $error("busy not set on start");
    a_addr_inc: assert property (@(posedge clock_i) disable iff (rst_i) // [R16]
        ce_i && fs_r == FS_RUN && flash_o.wr && flash_i.done
        && !(do_wr && ir_r == IR_FADDR) |=> addr_r == $past(addr_r) + 16'h0001)
        else $error("address not advanced after program");
    a_erase_key: assert property (@(posedge clock_i) disable iff (rst_i) // [R17]
        $rose(flash_o.erase) |-> $past(wdata[17:10]) == ERASE_KEY)
        else $error("erase without key");
    a_fail_track: assert property (@(posedge clock_i) disable iff (rst_i) // [R2]
        ce_i && fs_r == FS_RUN && flash_i.done |=> fail_r == $past(flash_i.fail))
        else $error("fail flag wrong");
    sequence s_one_cycle_strobe;
        flash_o.rd ##1 !flash_o.rd;
    endsequence
    a_short_strobe: assert property (@(posedge clock_i) disable iff (rst_i) // [R5]
        ce_i && fs_r == FS_IDLE && start_read && flash_ok && !scale_r[SCL_OSE]
        |=> s_one_cycle_strobe)
        else $error("read strobe not one cycle wide");
    a_sense_read: assert property (@(posedge clock_i) disable iff (rst_i) // [R6]
        flash_o.rd |-> flash_o.sense)
        else $error("sense off during read strobe");
endmodule // jfp_port

//--- rtl/jfp_pkg.sv
// Package: constants and types for the scan-side flash register port
package jfp_pkg;

    // ************************************************************
    // Instruction codes (16-bit instruction register)
    // ************************************************************
    localparam logic [15:0] IR_IDENT   = 16'h0004;   // Identification select
    localparam logic [15:0] IR_BYPASS  = 16'hffff;   // Bypass select
    localparam logic [15:0] IR_FCTRL   = 16'h0082;   // Flash control select
    localparam logic [15:0] IR_FDATA   = 16'h0083;   // Flash data select
    localparam logic [15:0] IR_FADDR   = 16'h0084;   // Flash address select
    localparam logic [15:0] IR_FSCALE  = 16'h0085;   // Flash scale select
    localparam int          IR_LEN     = 16;         // Instruction length
    localparam int          IND_LEN    = 20;         // Indirect shift length
    localparam int          WDATA_MSB  = 17;         // Write data left-justified here

    // ************************************************************
    // Register fields and reset values
    // ************************************************************
    localparam int          DAT_MSB    = 9;          // Data byte top bit
    localparam int          DAT_LSB    = 2;          // Data byte bottom bit
    localparam int          DAT_FAIL   = 1;          // Failure flag position
    localparam int          DAT_BUSY   = 0;          // Busy flag position
    localparam int          SCL_OSE    = 7;          // One-shot strobe enable bit
    localparam int          SCL_RAE    = 6;          // Read-always enable bit
    localparam logic [7:0]  SCL_WMASK  = 8'hcf;      // Bits 5:4 are not stored
    localparam logic [3:0]  PRESC_OFF  = 4'hf;       // All-ones prescale blocks flash
    localparam logic [3:0]  WM_PROG    = 4'h1;       // Write mode: program byte
    localparam logic [3:0]  WM_ERASE   = 4'h2;       // Write mode: erase page
    localparam logic [3:0]  RM_BLOCK   = 4'h1;       // Read mode: read on every access
    localparam logic [3:0]  RM_SINGLE  = 4'h2;       // Read mode: read once consumed
    localparam logic [7:0]  ERASE_KEY  = 8'ha5;      // Erase unlock byte
    localparam logic [15:0] ADDR_RST   = 16'h0000;   // Address reset value
    localparam logic [9:0]  DATA_RST   = 10'h000;    // Data reset value
    localparam logic [7:0]  SCALE_RST  = 8'h00;      // Scale reset value
    localparam logic [7:0]  CTRL_RST   = 8'h00;      // Control reset value

    // ************************************************************
    // Identity fields (arbitrary values, not a real part)
    // ************************************************************
    localparam logic [3:0]  ID_VERSION = 4'h1;       // Arbitrary version
    localparam logic [15:0] ID_PART    = 16'h0a5a;   // Arbitrary part number
    localparam logic [10:0] ID_MAKER   = 11'h155;    // Arbitrary maker code

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          CLK_PS     = 8000;       // System clock period, ps
    localparam int          OSE_PS     = 50000;      // One-shot strobe width, ps
    localparam int          OSE_CYC    = (OSE_PS + CLK_PS - 1) / CLK_PS; // Rounded up
    localparam int          CYC_W      = 8;          // Cycle counter width

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0]
    {
        TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SEL_DR = 4'h2, TS_CAP_DR = 4'h3,
        TS_SH_DR = 4'h4, TS_EX1_DR = 4'h5, TS_PA_DR = 4'h6, TS_EX2_DR = 4'h7,
        TS_UP_DR = 4'h8, TS_SEL_IR = 4'h9, TS_CAP_IR = 4'ha, TS_SH_IR = 4'hb,
        TS_EX1_IR = 4'hc, TS_PA_IR = 4'hd, TS_EX2_IR = 4'he, TS_UP_IR = 4'hf
    } jfp_tap_type;

    typedef enum logic [1:0]
    {
        FS_IDLE = 2'b00, FS_RUN = 2'b01, FS_DONE = 2'b10
    } jfp_fsm_type;

    // Flash array port bundle
    typedef struct packed
    {
        logic        rd;      // Read strobe
        logic        wr;      // Program strobe
        logic        erase;   // Page erase strobe
        logic        sense;   // Output/sense enable
        logic [15:0] addr;    // Byte address
        logic [7:0]  wdata;   // Program data
        logic [3:0]  presc;   // Timing prescale
    } jfp_flash_req_type;

    typedef struct packed
    {
        logic        done;    // Operation complete pulse
        logic        fail;    // Operation failed
        logic [7:0]  rdata;   // Read data
    } jfp_flash_rsp_type;

endpackage : jfp_pkg

//--- rtl/jfp_sync.sv
// Two-flop synchroniser for the scan pins
`timescale 1ns/1ps
module jfp_sync
    import jfp_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Async inputs
    input  wire logic [2:0] async_i,
    // Synchronised outputs
    output logic      [2:0] sync_o
);
    logic [2:0] meta_r;   // First stage, read only by second

    // ************************************************************
    // Two stages
    // ************************************************************
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_r <= 3'h0;
            sync_o <= 3'h0;
        end
        else if (ce_i)
        begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule // jfp_sync

//--- verif/jfp_flash_model.sv
// Flash array model that answers the port's strobes
`timescale 1ns/1ps
module jfp_flash_model
    import jfp_pkg::*;
(
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    // Array side
    input  wire jfp_flash_req_type req_i,
    output jfp_flash_rsp_type      rsp_o,
    // Observation
    output logic [7:0]             ops_o,
    output logic [7:0]             wdata_o
);
    logic strb_r; // Any strobe seen last cycle
    int   wait_r; // Cycles left until done
    // Slow on purpose so busy can be polled high; upper half is locked
    always @(negedge clock_i)
    begin
        rsp_o.done <= 1'b0;
        strb_r     <= req_i.rd | req_i.wr | req_i.erase;
        if (rst_i)
        begin
            rsp_o  <= '0;
            ops_o  <= 8'h00;
            wait_r <= 0;
        end
        else if ((req_i.rd | req_i.wr | req_i.erase) && !strb_r)
        begin
            wait_r  <= 600;
            ops_o   <= ops_o + 8'h01;
            wdata_o <= req_i.wdata;
        end
        else if (wait_r == 1)
        begin
            rsp_o.done  <= 1'b1;
            rsp_o.fail  <= req_i.addr[15];
            rsp_o.rdata <= ~req_i.addr[7:0];
            wait_r      <= 0;
        end
        else if (wait_r > 1)
            wait_r <= wait_r - 1;
    end
endmodule // jfp_flash_model

//--- verif/jtag_flash_register_port_tb_top.sv
// Testbench for the scan-side flash register port
`timescale 1ns/1ps
module jtag_flash_register_port_tb_top;
    import jfp_pkg::*;
    logic              clock_i = 1'b0; // System clock
    logic              rst_i   = 1'b1; // Reset, held at start
    logic              tck = 1'b0, tms = 1'b1, tdi = 1'b0, halt = 1'b0; // Scan, debug
    logic              tdo, oe, wdog, frz; // Port outputs
    jfp_flash_req_type req;            // Strobes to the array
    jfp_flash_rsp_type rsp;            // Array answers
    logic [7:0]        ops, wdat;      // Op count, data field at last strobe
    logic [31:0]       so;             // Bits shifted out
    int                failures = 0, compares = 0;
    int                rd_len = 0;     // Cycles with read strobe up
    initial forever #4 clock_i = ~clock_i;
    // Strobe counted mid-cycle, where it is settled
    always @(negedge clock_i)
        if (req.rd === 1'b1)
            rd_len++;
    jfp_port i_jfp_port (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(oe), .flash_o(req), .flash_i(rsp),
        .cpu_halted_i(halt), .watchdog_hold_o(wdog), .periph_freeze_o(frz));
    jfp_flash_model i_jfp_flash_model (.clock_i(clock_i), .rst_i(rst_i), .req_i(req),
        .rsp_o(rsp), .ops_o(ops), .wdata_o(wdat));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One 80 ns scan period; tdo taken at the rise, when it is settled
    task automatic tk(input logic m, input logic d);
        @(negedge clock_i);
        tms = m;
        tdi = d;
        tck = 1'b0;
        repeat (5) @(negedge clock_i);
        tck = 1'b1;
        so  = {tdo, so[31:1]};
        repeat (4) @(negedge clock_i);
    endtask
    // Idle to idle: shift n bits, LSB first, into IR or DR
    task automatic sh(input logic ir, input int n, input logic [31:0] d);
        logic [31:0] got; // Bits seen during the data phase only
        tk(1'b1, 1'b0);
        if (ir)
            tk(1'b1, 1'b0);
        tk(1'b0, 1'b0);
        tk(1'b0, 1'b0);
        for (int i = 0; i < n; i++)
            tk(i == n - 1, d[i]);
        got = so >> (32 - n);
        chk(oe, 1'b1);
        tk(1'b1, 1'b0);
        tk(1'b0, 1'b0);
        chk(oe, 1'b0);
        so = got;
    endtask
    // Bounded poll until busy reads low
    task automatic poll();
        for (int k = 0; k < 20; k++)
        begin
            sh(1'b0, IND_LEN, 32'h0);
            if (so[0] === 1'b0)
                return;
        end
        failures++;
        give_verdict();
    endtask
    task automatic wr(input logic [15:0] r, input logic [17:0] d);
        sh(1'b1, IR_LEN, {16'h0, r});
        sh(1'b0, IND_LEN, {12'h0, 2'b11, d});
        poll();
    endtask
    task automatic rd(input logic [15:0] r, input logic [13:0] e);
        sh(1'b1, IR_LEN, {16'h0, r});
        sh(1'b0, IND_LEN, {12'h0, 2'b10, 18'h0});
        poll();
        chk(so[18:5], e);
    endtask
    initial
    begin
        repeat (2) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clock_i);
        tk(1'b0, 1'b0);
        sh(1'b0, 32, 32'h0);
        chk(so, {ID_VERSION, ID_PART, ID_MAKER, 1'b1});
        sh(1'b1, IR_LEN, {16'h0, IR_BYPASS});
        sh(1'b0, 2, 32'h1);
        chk(so[1:0], 2'b10);
        wr(IR_FSCALE, {8'hff, 10'h0});
        rd(IR_FSCALE, 14'h0cf);
        chk(req.sense, 1'b1);
        wr(IR_FCTRL, {8'h10, 10'h0});
        wr(IR_FDATA, {8'h3c, 10'h0});
        chk(ops, 8'h00);
        rd(IR_FDATA, {4'h0, 8'h3c, 2'b10});
        wr(IR_FSCALE, {8'h0c, 10'h0});
        chk(req.sense, 1'b0);
        wr(IR_FADDR, {16'h0012, 2'b00});
        sh(1'b1, IR_LEN, {16'h0, IR_FDATA});
        sh(1'b0, IND_LEN, {12'h0, 2'b11, 8'h3c, 10'h0});
        sh(1'b0, IND_LEN, {12'h0, 2'b11, 8'h77, 10'h0});
        chk(so[0], 1'b1);
        poll();
        chk(ops, 8'h01);
        chk(wdat, 8'h3c);
        rd(IR_FADDR, 14'h0013);
        rd(IR_FDATA, {4'h0, 8'h3c, 2'b00});
        wr(IR_FADDR, {16'h8000, 2'b00});
        wr(IR_FDATA, {8'h11, 10'h0});
        rd(IR_FDATA, {4'h0, 8'h11, 2'b10});
        rd(IR_FADDR, 14'h0001);
        wr(IR_FCTRL, {8'h20, 10'h0});
        wr(IR_FDATA, {8'h5a, 10'h0});
        chk(ops, 8'h02);
        wr(IR_FDATA, {8'ha5, 10'h0});
        chk(ops, 8'h03);
        wr(IR_FSCALE, {8'h8c, 10'h0});
        wr(IR_FCTRL, {8'h01, 10'h0});
        wr(IR_FADDR, {16'h0020, 2'b00});
        rd(IR_FDATA, {4'h0, 8'hdf, 2'b00});
        chk(rd_len, OSE_CYC);
        wr(IR_FSCALE, {8'h0c, 10'h0});
        wr(IR_FCTRL, {8'h02, 10'h0});
        wr(IR_FADDR, {16'h0041, 2'b00});
        rd(IR_FDATA, {4'h0, 8'hdf, 2'b00});
        rd(IR_FDATA, {4'h0, 8'hbe, 2'b00});
        chk(ops, 8'h05);
        chk(rd_len, OSE_CYC + 1);
        halt = 1'b1;
        repeat (2) @(negedge clock_i);
        chk(wdog, 1'b1);
        chk(frz, 1'b0);
        halt = 1'b0;
        repeat (2) @(negedge clock_i);
        chk(wdog, 1'b0);
        give_verdict();
    end
endmodule // jtag_flash_register_port_tb_top
